// ---- hdl/uic_pkg.sv ----
// Constants, register map and types for the serial port control block
package uic_pkg;
	// Clock and line timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_HZ = 115_200;
	localparam int CLKS_PER_BIT = CLK_HZ / BAUD_HZ;
	localparam int RT_BITS = 32;
	// Datapath sizes
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int NIRQ = 11;
	localparam int NERR = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ERRCLR = 8'h08;
	localparam logic [7:0] OFS_RIS = 8'h0C;
	localparam logic [7:0] OFS_MIS = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	localparam logic [7:0] OFS_ICLR = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1C;
	localparam logic [7:0] OFS_MSET = 8'h20;
	localparam logic [7:0] OFS_MCLR = 8'h24;
	localparam logic [7:0] OFS_MCTL = 8'h28;
	localparam logic [7:0] OFS_MSTAT = 8'h2C;
	// Interrupt bit positions
	localparam int IRQ_RI = 0;
	localparam int IRQ_CTS = 1;
	localparam int IRQ_DCD = 2;
	localparam int IRQ_DSR = 3;
	localparam int IRQ_RX = 4;
	localparam int IRQ_TX = 5;
	localparam int IRQ_RT = 6;
	localparam int IRQ_FE = 7;
	// Error flag positions; error irq bit is IRQ_FE plus this
	localparam int ERR_FE = 0;
	localparam int ERR_PE = 1;
	localparam int ERR_BE = 2;
	localparam int ERR_OE = 3;
	// Control fields
	localparam int CTRL_W = 5;
	localparam int CTRL_TX_GATE = 0;
	localparam int CTRL_RX_RTS = 1;
	localparam int CTRL_PAR_LSB = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	// Modem control and modem status bits
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MS_CTS = 0;
	localparam int MS_DSR = 1;
	localparam int MS_DCD = 2;
	localparam int MS_RI = 3;
	// Status bits
	localparam int ST_HOLD_FULL = 0;
	localparam int ST_TX_BUSY = 1;
	localparam int ST_RX_AVAIL = 2;
	localparam int ST_RX_FULL = 3;
	localparam int ST_ERR_LSB = 4;
	// Parity modes
	localparam logic [2:0] PARITY_OFF = 3'h0;
	localparam logic [2:0] PARITY_EVEN = 3'h1;
	localparam logic [2:0] PARITY_ODD = 3'h2;
	localparam logic [2:0] PARITY_STUCK_HIGH = 3'h3;
	localparam logic [2:0] PARITY_STUCK_LOW = 3'h4;
	// AHB-Lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	// Serial frame states
	typedef enum logic [2:0] {
		FR_IDLE, FR_START, FR_DATA, FR_PAR, FR_STOP
	} uic_state_t;
	// Parity bit for a byte under a mode
	function automatic logic uic_par_bit(input logic [2:0] mode,
		input logic [DATA_W-1:0] d);
		case (mode)
			PARITY_EVEN: uic_par_bit = ^d;
			PARITY_ODD: uic_par_bit = ~^d;
			PARITY_STUCK_HIGH: uic_par_bit = 1'b1;
			default: uic_par_bit = 1'b0;
		endcase
	endfunction
endpackage

// ---- hdl/uic_top.sv ----
// Serial port with flow control, modem lines, interrupts and receive FIFO
//
// Notes on behaviour
// - With tx gating on, a character starts only while clear-to-send is asserted.
// - With auto rts on, hardware asserts rts only while receive FIFO has room.
// - Interrupt clear resets the named pending flags, others untouched.
// - Interrupt output is OR of pending sources that are enabled.
// - Eleven separately maskable sources: errors, timeout, tx, rx, modem changes.
// - Software reads raw pending status and masked status.
// - Modem set command asserts selected dtr and/or rts only.
// - Modem clear command deasserts selected dtr and/or rts only.
// - Software reads back present state of dtr and rts outputs.
// - Software reads present state of ri, dcd, dsr and cts inputs.
// - One parity mode governs both transmit generation and receive check.
// - Stuck modes send and expect a fixed parity level.
// - Error flags stay latched until error clear; re-interrupt only after clear.
// - Overrun flag sets when the overrun happens, not on next read.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

// Flip-flop FIFO with valid/ready on both sides
module uic_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Handshake terms
	assign o_in_ready = (count != FULL);
	assign o_out_valid = (count != '0);
	assign o_out_data = mem[rd_ptr];
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;

	// Pointer and count update
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// Pointer registers and storage
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			if (push) begin
				mem[wr_ptr] <= i_in_data;
			end
		end
	end
endmodule

module uic_top #(
	parameter int BIT_CLKS = uic_pkg::CLKS_PER_BIT,
	parameter int RT_CLKS = uic_pkg::RT_BITS * uic_pkg::CLKS_PER_BIT,
	parameter int FIFO_DEPTH = uic_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Serial data
	input wire logic i_rxd,
	output logic o_txd,
	// Modem lines, active low at the pins
	input wire logic i_cts_b,
	input wire logic i_dsr_b,
	input wire logic i_dcd_b,
	input wire logic i_ri_b,
	output logic o_rts_b,
	output logic o_dtr_b,
	// Processor interrupt
	output logic o_irq
);
	import uic_pkg::*;
	localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
	localparam logic [15:0] BIT_HALF = 16'(BIT_CLKS / 2);
	localparam logic [19:0] RT_LAST = 20'(RT_CLKS - 1);

	// Sync chain bit order: rxd, cts, dsr, dcd, ri
	logic [4:0] sync1, sync2, sync3;
	logic rxd, cts_on;
	logic [3:0] mstat;
	// Bus and register state
	logic dp_wr, next_dp_wr;
	logic [7:0] dp_addr, next_dp_addr;
	logic [31:0] next_hrdata;
	logic [CTRL_W-1:0] ctrl, next_ctrl;
	logic [NIRQ-1:0] imask, next_imask, ris, next_ris, evt;
	logic [NERR-1:0] err, next_err, new_err;
	logic sw_dtr, next_sw_dtr, sw_rts, next_sw_rts;
	logic next_rts_b, next_irq;
	logic rd_ap, wr_data, errclr;
	logic [2:0] pmode;
	// Transmit state
	uic_state_t tx_st, next_tx_st;
	logic [15:0] tx_cnt, next_tx_cnt;
	logic [2:0] tx_idx, next_tx_idx;
	logic [DATA_W-1:0] tx_hold, next_tx_hold, tx_byte, next_tx_byte;
	logic tx_hold_v, next_tx_hold_v, next_txd, tx_load;
	// Receive state
	uic_state_t rx_st, next_rx_st;
	logic [15:0] rx_cnt, next_rx_cnt;
	logic [2:0] rx_idx, next_rx_idx;
	logic [DATA_W-1:0] rx_shift, next_rx_shift;
	logic rx_parbit, next_rx_parbit, rx_done;
	logic [19:0] rt_cnt, next_rt_cnt;
	logic rt_hit, next_rt_hit;
	// FIFO handshake
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [DATA_W-1:0] fifo_out_data;

	// Pins pass two flops; third stage only for change detect
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			sync1 <= 5'h1F;
			sync2 <= 5'h1F;
			sync3 <= 5'h1F;
		end else begin
			sync1 <= {i_ri_b, i_dcd_b, i_dsr_b, i_cts_b, i_rxd};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign rxd = sync2[0];
	assign mstat = ~sync2[4:1];
	assign cts_on = mstat[MS_CTS];
	assign pmode = ctrl[CTRL_PAR_LSB +: 3];

	// Bus decode and receive FIFO pop on a data read
	assign rd_ap = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
	assign wr_data = dp_wr;
	assign errclr = wr_data && (dp_addr == OFS_ERRCLR);
	assign fifo_pop = rd_ap && (i_haddr[7:0] == OFS_DATA);

	// Events into the pending flags
	always_comb begin
		evt = '0;
		evt[IRQ_RI] = sync2[4] ^ sync3[4];
		evt[IRQ_DCD] = sync2[3] ^ sync3[3];
		evt[IRQ_DSR] = sync2[2] ^ sync3[2];
		evt[IRQ_CTS] = sync2[1] ^ sync3[1];
		evt[IRQ_RX] = rx_done & fifo_in_ready;
		evt[IRQ_TX] = tx_load;
		evt[IRQ_RT] = next_rt_hit & ~rt_hit;
		evt[IRQ_FE +: NERR] = new_err & ~err;
	end

	// Register file next values
	always_comb begin
		next_dp_wr = i_hsel & i_hready & i_htrans[1] & i_hwrite;
		next_dp_addr = i_haddr[7:0];
		next_ctrl = ctrl;
		next_imask = imask;
		next_sw_dtr = sw_dtr;
		next_sw_rts = sw_rts;
		next_ris = ris;
		if (wr_data) begin
			case (dp_addr)
				OFS_CTRL: next_ctrl = i_hwdata[CTRL_W-1:0];
				OFS_IMASK: next_imask = i_hwdata[NIRQ-1:0];
				OFS_ICLR: next_ris = ris & ~i_hwdata[NIRQ-1:0];
				OFS_MSET: begin
					next_sw_dtr = sw_dtr | i_hwdata[MC_DTR];
					next_sw_rts = sw_rts | i_hwdata[MC_RTS];
				end
				OFS_MCLR: begin
					next_sw_dtr = sw_dtr & ~i_hwdata[MC_DTR];
					next_sw_rts = sw_rts & ~i_hwdata[MC_RTS];
				end
				default: next_ctrl = ctrl;
			endcase
		end
		// Hardware set wins over software clear
		next_ris = next_ris | evt;
		next_err = (err & ~{NERR{errclr}}) | new_err;
		// Auto rts follows FIFO room, else software bit
		if (ctrl[CTRL_RX_RTS]) begin
			next_rts_b = ~fifo_in_ready;
		end else begin
			next_rts_b = ~sw_rts;
		end
		next_irq = |(ris & imask);
		next_hrdata = '0;
		if (rd_ap) begin
			case (i_haddr[7:0])
				OFS_DATA: next_hrdata[DATA_W-1:0] = fifo_out_data;
				OFS_STAT: begin
					next_hrdata[ST_HOLD_FULL] = tx_hold_v;
					next_hrdata[ST_TX_BUSY] = (tx_st != FR_IDLE);
					next_hrdata[ST_RX_AVAIL] = fifo_out_valid;
					next_hrdata[ST_RX_FULL] = ~fifo_in_ready;
					next_hrdata[ST_ERR_LSB +: NERR] = err;
				end
				OFS_RIS: next_hrdata[NIRQ-1:0] = ris;
				OFS_MIS: next_hrdata[NIRQ-1:0] = ris & imask;
				OFS_IMASK: next_hrdata[NIRQ-1:0] = imask;
				OFS_CTRL: next_hrdata[CTRL_W-1:0] = ctrl;
				OFS_MCTL: begin
					next_hrdata[MC_DTR] = ~o_dtr_b;
					next_hrdata[MC_RTS] = ~o_rts_b;
				end
				OFS_MSTAT: next_hrdata[3:0] = mstat;
				default: next_hrdata = '0;
			endcase
		end
	end

	// Register file and bus outputs
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			ctrl <= CTRL_RST;
			imask <= '0;
			ris <= '0;
			err <= '0;
			sw_dtr <= 1'b0;
			sw_rts <= 1'b0;
			o_rts_b <= 1'b1;
			o_dtr_b <= 1'b1;
			o_irq <= 1'b0;
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp <= HRESP_OKAY;
		end else begin
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			ctrl <= next_ctrl;
			imask <= next_imask;
			ris <= next_ris;
			err <= next_err;
			sw_dtr <= next_sw_dtr;
			sw_rts <= next_sw_rts;
			o_rts_b <= next_rts_b;
			o_dtr_b <= ~sw_dtr;
			o_irq <= next_irq;
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= HRESP_OKAY;
		end
	end

	// Transmitter: hold register feeds an 8-bit frame
	always_comb begin
		next_tx_st = tx_st;
		next_tx_cnt = (tx_cnt == '0) ? BIT_LAST : tx_cnt - 1'b1;
		next_tx_idx = tx_idx;
		next_tx_byte = tx_byte;
		next_tx_hold = tx_hold;
		next_tx_hold_v = tx_hold_v;
		tx_load = 1'b0;
		case (tx_st)
			FR_IDLE: begin
				next_tx_cnt = BIT_LAST;
				// Gate on cts only when tx gating is on
				if (tx_hold_v && (!ctrl[CTRL_TX_GATE] || cts_on)) begin
					tx_load = 1'b1;
					next_tx_byte = tx_hold;
					next_tx_hold_v = 1'b0;
					next_tx_idx = '0;
					next_tx_st = FR_START;
				end
			end
			FR_START: if (tx_cnt == '0) next_tx_st = FR_DATA;
			FR_DATA: if (tx_cnt == '0) begin
				next_tx_idx = tx_idx + 1'b1;
				if (tx_idx == 3'(DATA_W - 1)) begin
					next_tx_st = (pmode == PARITY_OFF) ? FR_STOP : FR_PAR;
				end
			end
			FR_PAR: if (tx_cnt == '0) next_tx_st = FR_STOP;
			FR_STOP: if (tx_cnt == '0) next_tx_st = FR_IDLE;
			default: next_tx_st = FR_IDLE;
		endcase
		if (wr_data && dp_addr == OFS_DATA && !tx_hold_v) begin
			next_tx_hold = i_hwdata[DATA_W-1:0];
			next_tx_hold_v = 1'b1;
		end
		case (tx_st)
			FR_START: next_txd = 1'b0;
			FR_DATA: next_txd = tx_byte[tx_idx];
			FR_PAR: next_txd = uic_par_bit(pmode, tx_byte);
			default: next_txd = 1'b1;
		endcase
	end

	// Transmitter registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			tx_st <= FR_IDLE;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_byte <= '0;
			tx_hold <= '0;
			tx_hold_v <= 1'b0;
			o_txd <= 1'b1;
		end else begin
			tx_st <= next_tx_st;
			tx_cnt <= next_tx_cnt;
			tx_idx <= next_tx_idx;
			tx_byte <= next_tx_byte;
			tx_hold <= next_tx_hold;
			tx_hold_v <= next_tx_hold_v;
			o_txd <= next_txd;
		end
	end

	// Receiver: mid-bit sampling, error checks, idle timeout
	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = (rx_cnt == '0) ? BIT_LAST : rx_cnt - 1'b1;
		next_rx_idx = rx_idx;
		next_rx_shift = rx_shift;
		next_rx_parbit = rx_parbit;
		rx_done = 1'b0;
		new_err = '0;
		case (rx_st)
			FR_IDLE: begin
				next_rx_cnt = BIT_HALF;
				if (!rxd) next_rx_st = FR_START;
			end
			FR_START: if (rx_cnt == '0) begin
				next_rx_idx = '0;
				next_rx_st = rxd ? FR_IDLE : FR_DATA;
			end
			FR_DATA: if (rx_cnt == '0) begin
				next_rx_shift = {rxd, rx_shift[DATA_W-1:1]};
				next_rx_idx = rx_idx + 1'b1;
				if (rx_idx == 3'(DATA_W - 1)) begin
					next_rx_st = (pmode == PARITY_OFF) ? FR_STOP : FR_PAR;
				end
			end
			FR_PAR: if (rx_cnt == '0) begin
				next_rx_parbit = rxd;
				next_rx_st = FR_STOP;
			end
			FR_STOP: if (rx_cnt == '0) begin
				rx_done = 1'b1;
				next_rx_st = FR_IDLE;
				new_err[ERR_FE] = ~rxd;
				new_err[ERR_PE] = (pmode != PARITY_OFF) &&
					(rx_parbit != uic_par_bit(pmode, rx_shift));
				new_err[ERR_BE] = ~rxd && (rx_shift == '0) &&
					((pmode == PARITY_OFF) || !rx_parbit);
				new_err[ERR_OE] = ~fifo_in_ready;
			end
			default: next_rx_st = FR_IDLE;
		endcase
		// Timeout: data waiting and line idle for the window
		next_rt_cnt = rt_cnt;
		next_rt_hit = rt_hit;
		if (rx_st != FR_IDLE || !fifo_out_valid || fifo_pop) begin
			next_rt_cnt = '0;
			next_rt_hit = 1'b0;
		end else if (rt_cnt == RT_LAST) begin
			next_rt_hit = 1'b1;
		end else begin
			next_rt_cnt = rt_cnt + 1'b1;
		end
	end

	// Receiver registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			rx_st <= FR_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_shift <= '0;
			rx_parbit <= 1'b0;
			rt_cnt <= '0;
			rt_hit <= 1'b0;
		end else begin
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_idx <= next_rx_idx;
			rx_shift <= next_rx_shift;
			rx_parbit <= next_rx_parbit;
			rt_cnt <= next_rt_cnt;
			rt_hit <= next_rt_hit;
		end
	end

	// Receive FIFO; a full FIFO drops the character as overrun
	uic_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_in_valid(rx_done),
		.o_in_ready(fifo_in_ready),
		.i_in_data(rx_shift),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	// Checks on the control behaviour
	property p_cts_gate;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(tx_st == FR_IDLE && ctrl[CTRL_TX_GATE] && !cts_on)
			|=> (tx_st == FR_IDLE);
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("tx started without cts");
	property p_rts_auto;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		ctrl[CTRL_RX_RTS] |=> (o_rts_b == !$past(fifo_in_ready));
	endproperty
	a_rts_auto: assert property (p_rts_auto) else $error("auto rts wrong");
	property p_rts_sw;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		!ctrl[CTRL_RX_RTS] |=> (o_rts_b == !$past(sw_rts));
	endproperty
	a_rts_sw: assert property (p_rts_sw) else $error("rts not software");
	property p_iclr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(wr_data && dp_addr == OFS_ICLR && evt == '0)
			|=> (ris == ($past(ris) & ~$past(i_hwdata[NIRQ-1:0])));
	endproperty
	a_iclr: assert property (p_iclr) else $error("clear hit wrong flags");
	property p_irq;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		##1 (o_irq == |($past(ris) & $past(imask)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not masked OR");
	property p_mis_read;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(rd_ap && i_haddr[7:0] == OFS_MIS)
			|=> (o_hrdata[NIRQ-1:0] == ($past(ris) & $past(imask)));
	endproperty
	a_mis_read: assert property (p_mis_read) else $error("masked read wrong");
	property p_mset;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(wr_data && dp_addr == OFS_MSET && i_hwdata[MC_DTR])
			|=> ##1 !o_dtr_b;
	endproperty
	a_mset: assert property (p_mset) else $error("dtr not set");
	property p_mclr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(wr_data && dp_addr == OFS_MCLR && !i_hwdata[MC_DTR])
			|=> (sw_dtr == $past(sw_dtr));
	endproperty
	a_mclr: assert property (p_mclr) else $error("unselected dtr moved");
	property p_mstat;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(rd_ap && i_haddr[7:0] == OFS_MSTAT)
			|=> (o_hrdata[3:0] == $past(mstat));
	endproperty
	a_mstat: assert property (p_mstat) else $error("modem status wrong");
	property p_tx_par;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(tx_st == FR_PAR) |=> (o_txd == uic_par_bit($past(pmode),
			$past(tx_byte)));
	endproperty
	a_tx_par: assert property (p_tx_par) else $error("tx parity wrong");
	property p_err_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(err[ERR_FE] && !errclr) |=> err[ERR_FE];
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag lost");
	property p_overrun;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(rx_done && !fifo_in_ready) |=> (err[ERR_OE] && ris[IRQ_FE + ERR_OE]
			|| $past(err[ERR_OE]));
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun late");
	c_frame: cover property (@(posedge i_ref_clk) tx_st == FR_STOP);
	c_overrun: cover property (@(posedge i_ref_clk) rx_done && !fifo_in_ready);
	c_irq: cover property (@(posedge i_ref_clk) $rose(o_irq));
	c_rx_par: cover property (@(posedge i_ref_clk) rx_st == FR_PAR);
endmodule

// ---- tb/uic_peer.sv ----
// Serial peer model: sends frames to the port and captures its frames
`timescale 1ns/1ps
module uic_peer #(
	parameter int BIT_CLKS = 8
) (
	// Clock
	input wire logic i_ref_clk,
	// Serial lines seen from the peer
	input wire logic i_txd,
	output logic o_rxd
);
	// Line idles high, as with a pull-up
	initial o_rxd = 1'b1;

	// One frame out, LSB first; pon adds bit pb, stp is the stop level
	task automatic send(input logic [7:0] d, input logic pon,
		input logic pb, input logic stp);
		logic [10:0] f;
		f = pon ? {stp, pb, d, 1'b0} : {1'b1, stp, d, 1'b0};
		@(posedge i_ref_clk);
		for (int i = 0; i < (pon ? 11 : 10); i++) begin
			o_rxd <= f[i];
			repeat (BIT_CLKS) @(posedge i_ref_clk);
		end
		o_rxd <= 1'b1;
		repeat (BIT_CLKS * 2) @(posedge i_ref_clk);
	endtask

	// One frame in, sampled mid-bit; ok low if no start bit came
	task automatic rx(input logic pon, output logic [7:0] d,
		output logic pb, output logic ok);
		int n;
		n = 0;
		while (i_txd !== 1'b0 && n < 3000) begin
			@(posedge i_ref_clk);
			n++;
		end
		ok = (n < 3000);
		repeat (BIT_CLKS / 2) @(posedge i_ref_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CLKS) @(posedge i_ref_clk);
			if (i < 8)
				d[i] = i_txd;
			else
				pb = i_txd;
		end
		repeat (BIT_CLKS * 2) @(posedge i_ref_clk);
	endtask
endmodule

// ---- tb/uic_top_test.sv ----
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
module uic_top_test;
	import uic_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, txd, rxd, rts_b, dtr_b, irq;
	logic [3:0] mdm_b = 4'hF;
	int bad_count = 0;
	int check_count = 0;
	logic [31:0] rd;
	logic [7:0] d;
	logic pb, ok, low, ep;
	logic [7:0] ma[4] = '{OFS_MSET, OFS_MSET, OFS_MCLR, OFS_MCLR};
	logic [1:0] me[4] = '{2'h1, 2'h3, 2'h2, 2'h0};

	// Free-running clock
	always #5 clk = ~clk;

	uic_top #(.BIT_CLKS(8), .RT_CLKS(64), .FIFO_DEPTH(32)) uic_top_i (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_rxd(rxd), .o_txd(txd), .i_cts_b(mdm_b[0]),
		.i_dsr_b(mdm_b[1]), .i_dcd_b(mdm_b[2]), .i_ri_b(mdm_b[3]),
		.o_rts_b(rts_b), .o_dtr_b(dtr_b), .o_irq(irq));

	uic_peer #(.BIT_CLKS(8)) uic_peer_i (
		.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One bus phase; ends at the edge that samples hready high
	task automatic phase(output logic [31:0] r);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			r = hrdata;
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			bad_count++;
			finish_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		phase(r);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		phase(r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask

	// Wait n edges, then look at settled pins
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Even, odd and fixed levels computed here, not by the design
	function automatic logic exp_par(input int m, input logic [7:0] v);
		return (m == 1) ? ^v : (m == 2) ? ~^v : (m == 3);
	endfunction

	// Run watchdog
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		tick(0);
		chk({hresp, hready, irq, txd, rts_b, dtr_b}, 32'h17);
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_IMASK, 32'h0);
		rdc(8'h3C, 32'h0);
		// Handshake outputs set, clear and read back
		for (int i = 0; i < 4; i++) begin
			wr(ma[i], 32'(1 << (i % 2)));
			tick(3);
			chk({30'h0, ~rts_b, ~dtr_b}, 32'(me[i]));
			rdc(OFS_MCTL, 32'(me[i]));
		end
		// Modem inputs, change interrupts, mask and clear
		mdm_b <= 4'h0;
		tick(6);
		rdc(OFS_MSTAT, 32'hF);
		rdc(OFS_RIS, 32'hF);
		wr(OFS_ICLR, 32'h5);
		rdc(OFS_RIS, 32'hA);
		tick(2);
		chk(irq, 1'b0);
		wr(OFS_IMASK, 32'h2);
		rdc(OFS_IMASK, 32'h2);
		rdc(OFS_MIS, 32'h2);
		tick(2);
		chk(irq, 1'b1);
		wr(OFS_ICLR, 32'h2);
		tick(2);
		chk(irq, 1'b0);
		rdc(OFS_RIS, 32'h8);
		// Transmit held off while clear-to-send is deasserted
		mdm_b <= 4'h1;
		wr(OFS_CTRL, 32'h1);
		wr(OFS_DATA, 32'hA5);
		low = 1'b0;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			low = low | (txd === 1'b0);
		end
		chk(low, 1'b0);
		mdm_b <= 4'h0;
		uic_peer_i.rx(1'b0, d, pb, ok);
		chk({ok, d}, 32'h1A5);
		wr(OFS_CTRL, 32'h0);
		mdm_b <= 4'h1;
		wr(OFS_DATA, 32'h5A);
		uic_peer_i.rx(1'b0, d, pb, ok);
		chk({ok, d}, 32'h15A);
		// Every parity mode, both directions
		for (int m = 0; m < 5; m++) begin
			wr(OFS_CTRL, 32'(m << 2));
			wr(OFS_DATA, 32'(8'h31 + m));
			ep = exp_par(m, 8'(8'h31 + m));
			uic_peer_i.rx(m != 0, d, pb, ok);
			chk({ok, pb, d}, {22'h0, 1'b1, (m != 0) ? ep : 1'b1,
				8'(8'h31 + m)});
			uic_peer_i.send(8'(8'h31 + m), m != 0, ep, 1'b1);
			rdc(OFS_STAT, 32'h4);
			rdc(OFS_DATA, 32'(8'h31 + m));
			if (m != 0) begin
				uic_peer_i.send(8'h31, 1'b1, ~exp_par(m, 8'h31), 1'b1);
				rdc(OFS_STAT, 32'h24);
				rdc(OFS_STAT, 32'h24);
				rdc(OFS_DATA, 32'h31);
				wr(OFS_ERRCLR, 32'h0);
			end
		end
		// Framing error, then break, with parity off again
		wr(OFS_CTRL, 32'h0);
		uic_peer_i.send(8'h12, 1'b0, 1'b0, 1'b0);
		uic_peer_i.send(8'h00, 1'b0, 1'b0, 1'b0);
		rdc(OFS_STAT, 32'h54);
		wr(OFS_ERRCLR, 32'h0);
		rdc(OFS_STAT, 32'h4);
		bus(1'b0, OFS_DATA, 32'h0, rd);
		bus(1'b0, OFS_DATA, 32'h0, rd);
		// Fill receive FIFO under auto request-to-send
		wr(OFS_ICLR, 32'h7FF);
		wr(OFS_CTRL, 32'h2);
		tick(3);
		chk(rts_b, 1'b0);
		for (int i = 0; i < 32; i++)
			uic_peer_i.send(8'(i), 1'b0, 1'b0, 1'b1);
		tick(2);
		chk(rts_b, 1'b1);
		tick(70);
		rdc(OFS_RIS, 32'h50);
		rdc(OFS_STAT, 32'hC);
		// Overrun flag set without any read
		wr(OFS_ICLR, 32'h7FF);
		wr(OFS_IMASK, 32'h400);
		uic_peer_i.send(8'hEE, 1'b0, 1'b0, 1'b1);
		rdc(OFS_STAT, 32'h8C);
		tick(2);
		chk(irq, 1'b1);
		wr(OFS_ICLR, 32'h7FF);
		uic_peer_i.send(8'hEE, 1'b0, 1'b0, 1'b1);
		bus(1'b0, OFS_RIS, 32'h0, rd);
		chk(rd & 32'h400, 32'h0);
		wr(OFS_ERRCLR, 32'h0);
		uic_peer_i.send(8'hEE, 1'b0, 1'b0, 1'b1);
		bus(1'b0, OFS_RIS, 32'h0, rd);
		chk(rd & 32'h400, 32'h400);
		// Drain in order; room reopens request-to-send
		for (int i = 0; i < 32; i++)
			rdc(OFS_DATA, 32'(i));
		bus(1'b0, OFS_STAT, 32'h0, rd);
		chk(rd & 32'hF, 32'h0);
		tick(3);
		chk(rts_b, 1'b0);
		finish_test();
	end
endmodule
